/* File: hdl/vhb_pkg.sv */
package vhb_pkg;
  // Software register offsets on the plain register port
  localparam logic [7:0] OFF_MEM_SIZE   = 8'h00;
  localparam logic [7:0] OFF_MON_TIMING = 8'h04;
  localparam logic [7:0] OFF_RETRACE    = 8'h08;
  localparam logic [7:0] OFF_PATH       = 8'h0C;
  localparam logic [7:0] OFF_STATUS     = 8'h10;
  // Values after reset
  localparam logic [7:0] MEM_SIZE_RST   = 8'h00;
  localparam logic [7:0] MON_TIMING_RST = 8'h00;
  localparam logic [7:0] RETRACE_RST    = 8'h00;
  localparam logic [7:0] PATH_RST       = 8'h00;
  localparam logic [7:0] MISC_OUT_RST   = 8'h00;
  localparam logic [7:0] SETUP_RST      = 8'h00;
  localparam logic [15:0] STRAP_RST     = 16'h0000;
  // Field positions
  localparam int ROM_EN_BIT   = 0;
  localparam int MON_C_BIT    = 1;
  localparam int IRQ_CLR_BIT  = 4;
  localparam int IRQ_EN_BIT   = 5;
  localparam int PATH_IO16    = 0;
  localparam int PATH_MEM16   = 1;
  localparam int PATH_MCLK    = 2;
  localparam int STRAP_ROMS   = 0;
  localparam int STRAP_MODE   = 2;
  localparam int STRAP_CLKDIR = 3;
  localparam int MISC_CLK_LSB = 2;
  // Host I/O ports decoded inside the block
  localparam logic [15:0] IO_SETUP    = 16'h46E8;
  localparam logic [15:0] IO_ENABLE   = 16'h0102;
  localparam logic [15:0] IO_MISC_OUT = 16'h03C2;
  // Memory windows: video memory by A23..A17, ROM by A23..A15
  localparam logic [6:0] VMEM_HI = 7'h05;
  localparam logic [8:0] ROM_HI  = 9'h018;
  // Pixel clock select codes
  localparam logic [1:0] PIX_A    = 2'h0;
  localparam logic [1:0] PIX_B    = 2'h1;
  localparam logic [1:0] PIX_C    = 2'h2;
  localparam logic [1:0] PIX_MCLK = 2'h3;
  // Write buffer entry layout
  localparam int WB_DATA_LSB = 0;
  localparam int WB_BE_LSB   = 16;
  localparam int WB_ADDR_LSB = 18;
  localparam int WB_ENTRY_W  = 35;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_WR_FULL = 5'h02,
    ST_RD_DRN  = 5'h04,
    ST_RD_WAIT = 5'h08,
    ST_HOLD    = 5'h10
  } vhb_state_type;
endpackage

/* File: hdl/vhb_host_if.sv */
// Summary of operation
// [R1] Strap bit 2 picks bus mode until reset
// [R2] Programmable 8/16-bit I/O and memory paths
// [R3] Memory writes posted into write buffer
// [R4] Wait states only on video memory accesses
// [R5] Ready low stretches cycle, high completes
// [R6] Setup 46E8H and enable 102H decoded inside
// [R7] Straps loaded from memory data pins
// [R8] Reset held ten clocks with clocks running
// [R9] Misc bits 3:2 zero select clock a
// [R10] Clock b direction strapped; pulses on 3C2H
// [R11] Clock c follows b; shows timing bit 1
// [R12] Upper address ignored for I/O decode
// [R13] Frame interrupt enabled, latched, cleared by bits
// [R14] Wide select claims 16-bit transfers
// [R15] Decode enable pin meaning per mode
// [R16] ROM select for C0000H-C7FFFH when enabled
// [R17] Write to 46E8H strobes ROM enable
// [R18] Two ROMs: byte swap enable on reads
// [R19] Memory decode only while enable high
// [R20] Memory clock selectable as dot clock
// [R21] Buffer direction high during read cycles
// [R22] Host uses high byte enable with A0
// [R23] Write stalls only when buffer full
`timescale 1ns/10ps
module vhb_host_if #(
  parameter int WB_DEPTH = 4
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [15:0] strap_md_in,
  input  wire logic [23:0] host_addr,
  input  wire logic [15:0] host_data_in,
  output logic      [15:0] host_data_out,
  output logic             host_data_oe_n,
  input  wire logic        mem_rd_n,
  input  wire logic        mem_wr_n,
  input  wire logic        io_rd_n,
  input  wire logic        io_wr_n,
  input  wire logic        high_byte_enable_n,
  input  wire logic        io_decode_enable_n,
  input  wire logic        mem_decode_enable,
  output logic             host_wait_ready,
  output logic             mem_wide_select_n,
  output logic             io_wide_select,
  output logic             rom_enable_n,
  output logic             rom_byte_swap_enable_n,
  output logic             buffer_direction,
  output logic             frame_interrupt_n,
  input  wire logic        vde_pulse,
  input  wire logic        video_clock_in_b,
  output logic             video_clock_out_b,
  output logic             video_clock_oe_b_n,
  input  wire logic        video_clock_in_c,
  output logic             video_clock_out_c,
  output logic             video_clock_oe_c_n,
  output logic      [1:0]  pix_clk_sel,
  output logic             dm_wr_valid,
  input  wire logic        dm_wr_ready,
  output logic      [16:0] dm_wr_addr,
  output logic      [15:0] dm_wr_data,
  output logic      [1:0]  dm_wr_be,
  output logic             dm_rd_req,
  output logic      [16:0] dm_rd_addr,
  input  wire logic        dm_rd_ack,
  input  wire logic [15:0] dm_rd_data,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata
);
  localparam int CW = $clog2(WB_DEPTH + 1);
  localparam int EW = vhb_pkg::WB_ENTRY_W;

  vhb_pkg::vhb_state_type state;
  vhb_pkg::vhb_state_type next_state;
  logic [15:0]   straps;
  logic          strap_taken;
  logic [7:0]    mem_size_reg;
  logic [7:0]    monitor_timing_reg;
  logic [7:0]    retrace_end_reg;
  logic [7:0]    path_reg;
  logic [7:0]    misc_out;
  logic [7:0]    setup_val;
  logic          vid_enable;
  logic          irq_pend;
  logic          mem_q;
  logic [CW-1:0] wb_count;
  logic [EW-1:0] wb_slot [WB_DEPTH];

  // Strapped configuration, fixed until the next reset; path bits come from the software path register
  wire mode_isa  = straps[vhb_pkg::STRAP_MODE];
  wire clk_out   = straps[vhb_pkg::STRAP_CLKDIR];
  wire two_roms  = straps[vhb_pkg::STRAP_ROMS];
  wire io16_en   = path_reg[vhb_pkg::PATH_IO16];
  wire mem16_en  = path_reg[vhb_pkg::PATH_MEM16];
  wire mclk_sel  = path_reg[vhb_pkg::PATH_MCLK];

  // Bus strobes: the channel reuses the pins as M/IO, S0, S1 and command
  wire ch_cmd    = ~io_wr_n;
  wire ch_wr     = ~mem_wr_n & io_rd_n;
  wire ch_rd     = mem_wr_n & ~io_rd_n;
  wire cyc_mem_rd = mode_isa ? ~mem_rd_n : (ch_cmd & mem_rd_n & ch_rd);
  wire cyc_mem_wr = mode_isa ? ~mem_wr_n : (ch_cmd & mem_rd_n & ch_wr);
  wire cyc_io_rd  = mode_isa ? ~io_rd_n : (ch_cmd & ~mem_rd_n & ch_rd);
  wire cyc_io_wr  = mode_isa ? ~io_wr_n : (ch_cmd & ~mem_rd_n & ch_wr);

  // Address decode; I/O looks at A15..A0 only
  wire        io_dec_ok  = strap_taken & (mode_isa ? ~io_decode_enable_n : io_decode_enable_n); // see [R15]
  wire        mem_dec_ok = strap_taken & mem_decode_enable & (mode_isa | io_decode_enable_n); // see [R19]
  wire [15:0] io_addr    = host_addr[15:0]; // see [R12]
  wire hit_setup = io_dec_ok & mode_isa & (io_addr == vhb_pkg::IO_SETUP); // see [R6]
  wire hit_en    = io_dec_ok & (io_addr == vhb_pkg::IO_ENABLE); // see [R6]
  wire hit_misc  = io_dec_ok & vid_enable & (io_addr == vhb_pkg::IO_MISC_OUT);
  wire hit_io    = hit_setup | hit_en | hit_misc;
  wire hit_vmem  = mem_dec_ok & vid_enable & (host_addr[23:17] == vhb_pkg::VMEM_HI);
  wire hit_rom   = mem_dec_ok & mode_isa & (host_addr[23:15] == vhb_pkg::ROM_HI)
                   & mem_size_reg[vhb_pkg::ROM_EN_BIT]; // see [R16]

  // Cycle starts and buffer bookkeeping
  wire cyc_mem      = cyc_mem_rd | cyc_mem_wr;
  wire mem_wr_start = cyc_mem_wr & hit_vmem & ~mem_q;
  wire mem_rd_start = cyc_mem_rd & hit_vmem & ~mem_q;
  wire wb_full      = wb_count == CW'(WB_DEPTH);
  wire pop          = dm_wr_valid & dm_wr_ready;
  wire push         = ((state == vhb_pkg::ST_IDLE) & mem_wr_start & ~wb_full)
                    | ((state == vhb_pkg::ST_WR_FULL) & ~wb_full); // see [R3]
  wire [CW-1:0] wr_idx     = CW'(wb_count - CW'(pop));
  wire [CW-1:0] next_count = CW'(wb_count + CW'(push) - CW'(pop));

  // Byte lanes: an 8-bit path carries the odd byte on the low lane
  wire [1:0]  in_be   = mem16_en ? {~high_byte_enable_n, ~host_addr[0]}
                                 : (host_addr[0] ? 2'h2 : 2'h1); // see [R2] see [R22]
  wire [15:0] in_data = mem16_en ? host_data_in : {host_data_in[7:0], host_data_in[7:0]};
  wire [EW-1:0] entry = {host_addr[16:0], in_be, in_data};
  wire [15:0] rd_fmt  = (~mem16_en & dm_rd_addr[0]) ? {8'h00, dm_rd_data[15:8]} : dm_rd_data;
  wire [15:0] io_rdata = hit_setup ? {8'h00, setup_val}
                       : hit_en ? {15'h0000, vid_enable}
                       : {8'h00, misc_out};
  wire [15:0] io_rfmt  = (~io16_en & io_addr[0]) ? {8'h00, io_rdata[15:8]} : io_rdata;

  // Head of the buffer feeds display memory directly
  assign dm_wr_addr = wb_slot[0][vhb_pkg::WB_ADDR_LSB +: 17];
  assign dm_wr_be   = wb_slot[0][vhb_pkg::WB_BE_LSB +: 2];
  assign dm_wr_data = wb_slot[0][vhb_pkg::WB_DATA_LSB +: 16];

  // Host cycle sequencer; reads wait for the buffer to drain to keep order
  always_comb begin
    next_state = state;
    unique case (state)
      vhb_pkg::ST_IDLE: begin
        if (mem_wr_start) begin
          next_state = wb_full ? vhb_pkg::ST_WR_FULL : vhb_pkg::ST_HOLD; // see [R23]
        end else if (mem_rd_start) begin
          next_state = vhb_pkg::ST_RD_DRN;
        end
      end
      vhb_pkg::ST_WR_FULL: begin
        if (!wb_full) begin
          next_state = vhb_pkg::ST_HOLD; // see [R23]
        end
      end
      vhb_pkg::ST_RD_DRN: begin
        if (wb_count == '0) begin
          next_state = vhb_pkg::ST_RD_WAIT;
        end
      end
      vhb_pkg::ST_RD_WAIT: begin
        if (dm_rd_ack) begin
          next_state = vhb_pkg::ST_HOLD;
        end
      end
      vhb_pkg::ST_HOLD: begin
        if (!cyc_mem) begin
          next_state = vhb_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Ready drops only in the stall states, so I/O and ROM are never stretched
  wire next_ready = (next_state == vhb_pkg::ST_IDLE) | (next_state == vhb_pkg::ST_HOLD); // see [R4] see [R5]
  wire rd_claim   = (cyc_io_rd & hit_io) | (cyc_mem_rd & hit_vmem);
  wire next_dir   = rd_claim | (cyc_mem_rd & hit_rom); // see [R21]
  wire next_rom_n = ~(hit_rom | (cyc_io_wr & hit_setup)); // see [R16] see [R17]
  wire next_swap_n = ~(two_roms & hit_rom & cyc_mem_rd & high_byte_enable_n & host_addr[0]); // see [R18]
  wire next_wide_n = mode_isa ? ~(mem16_en & hit_vmem)
                              : ~((mem16_en & hit_vmem) | (io16_en & hit_io)); // see [R14]
  wire next_iowide = mode_isa & io16_en & hit_io; // see [R2]
  wire next_irq    = (vde_pulse & retrace_end_reg[vhb_pkg::IRQ_EN_BIT])
                   | (irq_pend & retrace_end_reg[vhb_pkg::IRQ_CLR_BIT]); // see [R13]
  wire [1:0] misc_clk = misc_out[vhb_pkg::MISC_CLK_LSB +: 2];
  wire [1:0] next_pix = mclk_sel ? vhb_pkg::PIX_MCLK // see [R20]
                      : (clk_out | misc_clk == 2'h0 | misc_clk == 2'h3) ? vhb_pkg::PIX_A // see [R9]
                      : (misc_clk == 2'h1) ? vhb_pkg::PIX_B : vhb_pkg::PIX_C;
  wire reg_hit_status = reg_addr == vhb_pkg::OFF_STATUS;
  wire [7:0] status   = {irq_pend, mode_isa, clk_out, two_roms, vid_enable, 3'(wb_count)};
  wire [7:0] next_rdata = !reg_rd ? 8'h00
                        : (reg_addr == vhb_pkg::OFF_MEM_SIZE)   ? mem_size_reg
                        : (reg_addr == vhb_pkg::OFF_MON_TIMING) ? monitor_timing_reg
                        : (reg_addr == vhb_pkg::OFF_RETRACE)    ? retrace_end_reg
                        : (reg_addr == vhb_pkg::OFF_PATH)       ? path_reg
                        : reg_hit_status ? status : 8'h00;

  // Strap capture one clock after reset release, never under the reset itself
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      straps      <= vhb_pkg::STRAP_RST;
      strap_taken <= 1'b0;
    end else if (ce && !strap_taken) begin
      straps      <= strap_md_in; // see [R7] see [R1]
      strap_taken <= 1'b1;
    end
  end

  // Software registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_size_reg       <= vhb_pkg::MEM_SIZE_RST;
      monitor_timing_reg <= vhb_pkg::MON_TIMING_RST;
      retrace_end_reg    <= vhb_pkg::RETRACE_RST;
      path_reg           <= vhb_pkg::PATH_RST;
      reg_rdata          <= 8'h00;
    end else if (ce) begin
      reg_rdata <= next_rdata;
      if (reg_wr && reg_addr == vhb_pkg::OFF_MEM_SIZE) mem_size_reg <= reg_wdata;
      if (reg_wr && reg_addr == vhb_pkg::OFF_MON_TIMING) monitor_timing_reg <= reg_wdata;
      if (reg_wr && reg_addr == vhb_pkg::OFF_RETRACE) retrace_end_reg <= reg_wdata;
      if (reg_wr && reg_addr == vhb_pkg::OFF_PATH) path_reg <= reg_wdata;
    end
  end

  // Host I/O port writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      misc_out   <= vhb_pkg::MISC_OUT_RST;
      setup_val  <= vhb_pkg::SETUP_RST;
      vid_enable <= 1'b1;
    end else if (ce && cyc_io_wr) begin
      if (hit_misc) misc_out <= host_data_in[7:0];
      if (hit_setup) setup_val <= host_data_in[7:0];
      if (hit_en) vid_enable <= host_data_in[0];
    end
  end

  // Sequencer state, display memory read request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state      <= vhb_pkg::ST_IDLE;
      mem_q      <= 1'b0;
      dm_rd_req  <= 1'b0;
      dm_rd_addr <= 17'h00000;
    end else if (ce) begin
      state     <= next_state;
      mem_q     <= cyc_mem;
      dm_rd_req <= next_state == vhb_pkg::ST_RD_WAIT;
      if (mem_rd_start && state == vhb_pkg::ST_IDLE) dm_rd_addr <= host_addr[16:0];
    end
  end

  // Write buffer as a shift queue: the head always sits in slot 0
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wb_count    <= '0;
      dm_wr_valid <= 1'b0;
      for (int i = 0; i < WB_DEPTH; i++) wb_slot[i] <= '0;
    end else if (ce) begin
      wb_count    <= next_count;
      dm_wr_valid <= next_count != '0;
      for (int i = 0; i < WB_DEPTH; i++) begin
        if (pop && i < WB_DEPTH - 1) wb_slot[i] <= wb_slot[i + 1];
        if (push && wr_idx == CW'(i)) wb_slot[i] <= entry; // see [R3]
      end
    end
  end

  // Registered pin outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      host_wait_ready        <= 1'b1;
      host_data_out          <= 16'h0000;
      host_data_oe_n         <= 1'b1;
      buffer_direction       <= 1'b0;
      rom_enable_n           <= 1'b1;
      rom_byte_swap_enable_n <= 1'b1;
      mem_wide_select_n      <= 1'b1;
      io_wide_select         <= 1'b0;
      irq_pend               <= 1'b0;
      frame_interrupt_n      <= 1'b1;
      pix_clk_sel            <= vhb_pkg::PIX_A;
    end else if (ce) begin
      host_wait_ready        <= next_ready;
      host_data_oe_n         <= ~rd_claim;
      buffer_direction       <= next_dir;
      rom_enable_n           <= next_rom_n;
      rom_byte_swap_enable_n <= next_swap_n;
      mem_wide_select_n      <= next_wide_n;
      io_wide_select         <= next_iowide;
      irq_pend               <= next_irq;
      frame_interrupt_n      <= mode_isa ? next_irq : ~next_irq; // see [R13]
      pix_clk_sel            <= next_pix;
      if (state == vhb_pkg::ST_RD_WAIT && dm_rd_ack) host_data_out <= rd_fmt;
      else if (cyc_io_rd && hit_io) host_data_out <= io_rfmt;
    end
  end

  // Clock pins b and c share the strapped direction
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      video_clock_out_b  <= 1'b1;
      video_clock_oe_b_n <= 1'b1;
      video_clock_out_c  <= 1'b0;
      video_clock_oe_c_n <= 1'b1;
    end else if (ce) begin
      video_clock_oe_b_n <= ~clk_out; // see [R10]
      video_clock_oe_c_n <= ~clk_out; // see [R11]
      video_clock_out_b  <= ~(cyc_io_wr & hit_misc); // see [R10]
      video_clock_out_c  <= monitor_timing_reg[vhb_pkg::MON_C_BIT]; // see [R11]
    end
  end

  sequence wr_full_s;
    state == vhb_pkg::ST_IDLE && mem_wr_start && wb_full;
  endsequence
  sequence stall_s;
    !host_wait_ready ##1 state == vhb_pkg::ST_WR_FULL;
  endsequence

  mode_hold_a: assert property (@(posedge core_clk) disable iff (rst || !ce) // see [R1]
    strap_taken && $past(strap_taken) |-> $stable(mode_isa)) else $error("bus mode changed");
  io_no_wait_a: assert property (@(posedge core_clk) disable iff (rst || !ce) // see [R4]
    !host_wait_ready |-> state inside {vhb_pkg::ST_WR_FULL, vhb_pkg::ST_RD_DRN, vhb_pkg::ST_RD_WAIT})
    else $error("ready low outside a memory stall");
  full_stall_a: assert property (@(posedge core_clk) disable iff (rst || !ce) // see [R23]
    wr_full_s |=> stall_s or (!host_wait_ready ##0 !wb_full)) else $error("full buffer did not stall");
  post_write_a: assert property (@(posedge core_clk) disable iff (rst || !ce) // see [R3]
    state == vhb_pkg::ST_IDLE && mem_wr_start && !wb_full |=> host_wait_ready && wb_count != '0)
    else $error("posted write not buffered");
  ready_back_a: assert property (@(posedge core_clk) disable iff (rst || !ce) // see [R5]
    state == vhb_pkg::ST_RD_WAIT && dm_rd_ack |=> host_wait_ready && state == vhb_pkg::ST_HOLD)
    else $error("ready not restored");
  rd_order_a: assert property (@(posedge core_clk) disable iff (rst || !ce) // see [R3]
    $rose(dm_rd_req) |-> wb_count == '0 && !dm_wr_valid) else $error("read passed buffered write");
  irq_latch_a: assert property (@(posedge core_clk) disable iff (rst || !ce) // see [R13]
    vde_pulse && retrace_end_reg[5] && retrace_end_reg[4] |=> (frame_interrupt_n == mode_isa)[*2])
    else $error("frame interrupt not latched");
  clk_pulse_a: assert property (@(posedge core_clk) disable iff (rst || !ce) // see [R10]
    cyc_io_wr && hit_misc |=> !video_clock_out_b) else $error("clock b pulse missing");
  rom_sel_a: assert property (@(posedge core_clk) disable iff (rst || !ce) // see [R16]
    hit_rom |=> !rom_enable_n) else $error("rom select missing");
  io_gate_a: assert property (@(posedge core_clk) disable iff (rst || !ce) // see [R15]
    mode_isa && io_decode_enable_n && !cyc_mem_rd |=> host_data_oe_n) else $error("io decoded while disabled");
  pix_sel_a: assert property (@(posedge core_clk) disable iff (rst || !ce) // see [R9]
    !mclk_sel && !clk_out && misc_clk == 2'h0 |=> pix_clk_sel == vhb_pkg::PIX_A) else $error("pixel clock a");
  dir_read_a: assert property (@(posedge core_clk) disable iff (rst || !ce) // see [R21]
    rd_claim |=> buffer_direction && !host_data_oe_n) else $error("buffer direction wrong");
endmodule

/* File: dv/vhb_dm_model.sv */
`timescale 1ns/10ps
module vhb_dm_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        stall,
  input  wire logic        dm_wr_valid,
  output logic             dm_wr_ready,
  input  wire logic [16:0] dm_wr_addr,
  input  wire logic [15:0] dm_wr_data,
  input  wire logic [1:0]  dm_wr_be,
  input  wire logic        dm_rd_req,
  input  wire logic [16:0] dm_rd_addr,
  output logic             dm_rd_ack,
  output logic      [15:0] dm_rd_data
);
  logic [15:0] mem [0:255];
  logic [2:0]  dly;
  // Bench stalls the display side to fill the posted buffer
  assign dm_wr_ready = ~stall;
  // Reads answer after a few cycles; data toggles outside the ack so stale values never match
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dm_rd_ack  <= 1'b0;
      dly        <= 3'h0;
      dm_rd_data <= 16'h0000;
    end else begin
      if (dm_wr_valid && dm_wr_ready && dm_wr_be[0]) mem[dm_wr_addr[7:0]][7:0] <= dm_wr_data[7:0];
      if (dm_wr_valid && dm_wr_ready && dm_wr_be[1]) mem[dm_wr_addr[7:0]][15:8] <= dm_wr_data[15:8];
      dm_rd_ack  <= 1'b0;
      dm_rd_data <= ~dm_rd_data;
      if (!dm_rd_req) begin
        dly <= 3'h0;
      end else if (dly == 3'h3) begin
        dm_rd_ack  <= 1'b1;
        dm_rd_data <= mem[dm_rd_addr[7:0]];
        dly        <= 3'h7;
      end else if (dly != 3'h7 && !stall) begin
        dly <= dly + 3'h1;
      end
    end
  end
endmodule

/* File: dv/vhb_host_if_tb.sv */
`timescale 1ns/10ps
module vhb_host_if_tb;
  logic        core_clk, rst, ce, stall, mem_rd_n, mem_wr_n, io_rd_n, io_wr_n, bhe_n, mem_dec, vde;
  logic        reg_wr, reg_rd, rdy, rom_n, swap_n, dir, irq_n, ckb, ckb_oe, ckc, ckc_oe, wv, wr_rdy;
  logic        rq, ack, mws_n, iows, doe_n, saw_rom, saw_ckb, saw_wr, saw_rd, st, eio_n, clr;
  logic [23:0] host_addr;
  logic [15:0] hdi, hdo, wd, rdd, dat, rdat, md;
  logic [16:0] wa, ra;
  logic [1:0]  be, pix;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, r;
  integer      seed, errors, samples_checked, i;

  vhb_host_if #(.WB_DEPTH(2)) i_dut (.core_clk(core_clk), .rst(rst), .ce(ce), .strap_md_in(md),
    .host_addr(host_addr), .host_data_in(hdi), .host_data_out(hdo), .host_data_oe_n(doe_n), .mem_rd_n(mem_rd_n),
    .mem_wr_n(mem_wr_n), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .high_byte_enable_n(bhe_n),
    .io_decode_enable_n(eio_n), .mem_decode_enable(mem_dec), .host_wait_ready(rdy), .mem_wide_select_n(mws_n),
    .io_wide_select(iows), .rom_enable_n(rom_n), .rom_byte_swap_enable_n(swap_n), .buffer_direction(dir),
    .frame_interrupt_n(irq_n), .vde_pulse(vde), .video_clock_in_b(1'b0), .video_clock_out_b(ckb),
    .video_clock_oe_b_n(ckb_oe), .video_clock_in_c(1'b0), .video_clock_out_c(ckc), .video_clock_oe_c_n(ckc_oe),
    .pix_clk_sel(pix), .dm_wr_valid(wv), .dm_wr_ready(wr_rdy), .dm_wr_addr(wa), .dm_wr_data(wd), .dm_wr_be(be),
    .dm_rd_req(rq), .dm_rd_addr(ra), .dm_rd_ack(ack), .dm_rd_data(rdd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  vhb_dm_model i_mem (.core_clk(core_clk), .rst(rst), .stall(stall), .dm_wr_valid(wv), .dm_wr_ready(wr_rdy),
    .dm_wr_addr(wa), .dm_wr_data(wd), .dm_wr_be(be), .dm_rd_req(rq), .dm_rd_addr(ra), .dm_rd_ack(ack),
    .dm_rd_data(rdd));

  // Clock at 125 MHz
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Pulse catchers; cleared at an edge with clr high, so only this process drives them
  always @(posedge core_clk) begin
    if (clr) {saw_rom, saw_ckb, saw_wr, saw_rd} <= 4'h0;
    if (rom_n === 1'b0) saw_rom <= 1'b1;
    if (ckb === 1'b0 && ckb_oe === 1'b0) saw_ckb <= 1'b1;
    if (wv === 1'b1) saw_wr <= 1'b1;
    if (dir === 1'b1 && doe_n === 1'b0 && mws_n === 1'b0) saw_rd <= 1'b1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rw(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rr(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask
  // Status expected from the straps: nothing pending, video enabled, buffer empty
  function automatic logic [15:0] stat_exp(input logic [15:0] s);
    return {8'h00, 1'b0, s[vhb_pkg::STRAP_MODE], s[vhb_pkg::STRAP_CLKDIR], s[vhb_pkg::STRAP_ROMS], 1'b1, 3'h0};
  endfunction
  // Host cycle: 0 memory write, 1 memory read, 2 I/O write; strobe held until ready is seen high
  task automatic host(input int k, input logic [23:0] a, input logic [15:0] d);
    int n;
    clr <= 1'b1;
    @(posedge core_clk);
    clr       <= 1'b0;
    host_addr <= a;
    hdi       <= d;
    bhe_n     <= 1'b0;
    mem_wr_n  <= (k != 0);
    mem_rd_n  <= (k != 1);
    io_wr_n   <= (k != 2);
    @(posedge core_clk);
    @(posedge core_clk);
    #1 st = (rdy !== 1'b1);
    n = 0;
    while (rdy !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= 200) errors++;
    rdat = hdo;
    @(posedge core_clk);
    {mem_wr_n, mem_rd_n, io_wr_n} <= 3'h7;
    @(posedge core_clk);
    #1;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #400000;
    errors++;
    final_report;
  end

  initial begin
    seed = 32'hB98D7A7D;
    {errors, samples_checked} = 0;
    {rst, ce, stall, mem_dec, vde, reg_wr, reg_rd} = 7'h68;
    {mem_rd_n, mem_wr_n, io_rd_n, io_wr_n, bhe_n} = 5'h1F;
    {host_addr, hdi, reg_addr, reg_wdata} = 0;
    {eio_n, clr, md} = {2'h1, 16'h000D};
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rr(vhb_pkg::OFF_STATUS);
    check(16'(r), stat_exp(md));
    rr(8'hFC);
    check(16'(r), 16'h0000);
    check(16'(pix), 16'h0000);
    $display("test reset done");
    host(2, 24'h0046E8, 16'h0055);
    check(16'(saw_rom), 16'h0001);
    host(2, 24'hFE03C2, 16'h0004);
    check(16'({saw_ckb, st, pix}), 16'h0008);
    eio_n <= 1'b1;
    host(2, 24'h0046E8, 16'h00AA);
    check(16'(saw_rom), 16'h0000);
    eio_n <= 1'b0;
    $display("test io done");
    rw(vhb_pkg::OFF_PATH, 8'h03);
    stall <= 1'b1;
    host(0, 24'h0A0000, 16'h1234);
    host(0, 24'h0A0002, 16'h5678);
    check(16'(st), 16'h0000);
    fork
      host(0, 24'h0A0004, 16'h9ABC);
      begin
        repeat (8) @(posedge core_clk);
        stall <= 1'b0;
      end
    join
    check(16'(st), 16'h0001);
    $display("test posted done");
    for (i = 0; i < 8; i++) begin
      dat = 16'($random(seed));
      stall <= 1'($random(seed));
      host(0, 24'h0A0010 + 24'(i * 2), dat);
      stall <= 1'b0;
      host(1, 24'h0A0010 + 24'(i * 2), 16'h0000);
      check(rdat, dat);
      check(16'({st, saw_rd}), 16'h0003);
    end
    $display("test random done");
    rw(vhb_pkg::OFF_MEM_SIZE, 8'h01);
    host(1, 24'h0C0000, 16'h0000);
    check(16'({saw_rom, st}), 16'h0002);
    mem_dec <= 1'b0;
    host(0, 24'h0A0000, 16'hFFFF);
    check(16'({saw_wr, st}), 16'h0000);
    mem_dec <= 1'b1;
    $display("test decode done");
    rw(vhb_pkg::OFF_RETRACE, 8'h30);
    @(posedge core_clk);
    vde <= 1'b1;
    @(posedge core_clk);
    vde <= 1'b0;
    rr(vhb_pkg::OFF_STATUS);
    check(16'({r[7], irq_n}), 16'h0003);
    rw(vhb_pkg::OFF_RETRACE, 8'h20);
    rr(vhb_pkg::OFF_STATUS);
    check(16'({r[7], irq_n}), 16'h0000);
    $display("test interrupt done");
    rw(vhb_pkg::OFF_MON_TIMING, 8'h02);
    rw(vhb_pkg::OFF_PATH, 8'h07);
    repeat (2) @(posedge core_clk);
    #1 check(16'({ckc, ckc_oe, pix}), 16'h000B);
    $display("test clocks done");
    // Second reset restraps the block into channel mode
    rst   <= 1'b1;
    md    <= 16'h0000;
    eio_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rr(vhb_pkg::OFF_STATUS);
    check(16'(r), stat_exp(md));
    check(16'(irq_n), 16'h0001);
    $display("test channel done");
    final_report;
  end
endmodule
